/* fiber_regs_pkg.sv */
package fiber_regs_pkg;
   // Register indices; byte address is four times the index
   localparam logic [11:0] fiber_control_idx    = 12'hc00;
   localparam logic [11:0] fiber_status_idx     = 12'hc01;
   localparam logic [11:0] operating_mode_idx   = 12'hc08;
   localparam logic [11:0] link_inputs_idx      = 12'hc09;
   localparam logic [15:0] fiber_control_reset  = 16'h1140;
   localparam logic [15:0] fiber_status_fixed   = 16'h6149;
   localparam logic [15:0] control_write_mask   = 16'hffc0;
   // Control bit positions
   localparam int soft_reset_pos    = 15;
   localparam int loopback_pos      = 14;
   localparam int speed_low_pos     = 13;
   localparam int autoneg_en_pos    = 12;
   localparam int power_down_pos    = 11;
   localparam int isolate_pos       = 10;
   localparam int restart_pos       = 9;
   localparam int duplex_pos        = 8;
   localparam int col_test_pos      = 7;
   localparam int speed_high_pos    = 6;
   // Status bit positions
   localparam int neg_done_pos      = 5;
   localparam int far_fault_pos     = 4;
   localparam int link_up_pos       = 2;
   // Operating mode layout and reset value
   localparam int bridge_dir_pos    = 6;
   localparam logic [2:0] opmode_rgmii_1000x  = 3'h1;
   localparam logic [2:0] opmode_rgmii_100fx  = 3'h2;
   localparam logic [2:0] opmode_rgmii_sgmii  = 3'h3;
   localparam logic [2:0] opmode_mc_1000x     = 3'h4;
   localparam logic [2:0] opmode_mc_100fx     = 3'h5;
   localparam logic [2:0] opmode_sgmii_copper = 3'h6;
   localparam logic [15:0] operating_mode_reset = 16'h0040;
   // Soft reset hold time in cycles
   localparam int soft_reset_cycles = 16;
   localparam logic [1:0] speed_reserved = 2'h3;
   typedef enum logic [1:0] {reset_idle, reset_busy, reset_done} soft_reset_state_t;
endpackage

/* fiber_reg_if.sv */
`timescale 1ns/1ps
// Raw control and operating mode words passed from the register bank to the mode logic
interface fiber_reg_if;
   logic [15:0] control;
   logic [15:0] opmode;
   logic        soft_reset_busy;
   modport bank (output control, output opmode, input soft_reset_busy);
   modport mode (input control, input opmode, output soft_reset_busy);
endinterface

/* fiber_mode_logic.sv */
`timescale 1ns/1ps
// Mode-dependent control decode and soft reset sequencing
module fiber_mode_logic
   import fiber_regs_pkg::*;
(
   input  wire logic  clock_in,
   input  wire logic  srst_in,
   fiber_reg_if.mode  regs,
   input  wire logic  start_reset_in,
   input  wire logic  tx_enable_in,
   output logic       datapath_reset_out,
   output logic       loopback_out,
   output logic [1:0] speed_out,
   output logic       autoneg_on_out,
   output logic       isolate_out,
   output logic       full_duplex_out,
   output logic       collision_out
);
   soft_reset_state_t state_reg, state_next;
   logic [4:0] count_reg, count_next;
   wire logic [2:0] opmode      = regs.opmode[2:0];
   wire logic sgmii_to_rgmii    = (opmode == opmode_sgmii_copper) ||
                                  (opmode == opmode_rgmii_sgmii && !regs.opmode[bridge_dir_pos]);
   wire logic fiber_or_bridge   = (opmode != 3'h0) && (opmode != 3'h7);
   wire logic an_mode           = (opmode == opmode_rgmii_1000x) || (opmode == opmode_mc_1000x) ||
                                  (opmode == opmode_rgmii_sgmii) || (opmode == opmode_sgmii_copper);
   wire logic mii_100fx         = (opmode == opmode_rgmii_100fx) || (opmode == opmode_mc_100fx);

   // Soft reset sequencer
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      case (state_reg)
         reset_idle: begin
            if (start_reset_in) begin
               state_next = reset_busy;
               count_next = 5'(soft_reset_cycles - 1);
            end
         end
         reset_busy: begin
            if (count_reg == 5'h00) state_next = reset_done;
            else count_next = count_reg - 5'h01;
         end
         reset_done: state_next = reset_idle;
         default:    state_next = reset_idle;
      endcase
   end

   assign regs.soft_reset_busy = (state_reg == reset_busy);

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         state_reg          <= reset_idle;
         count_reg          <= 5'h00;
         datapath_reset_out <= 1'b1;
         loopback_out       <= 1'b0;
         speed_out          <= 2'h2;
         autoneg_on_out     <= 1'b0;
         isolate_out        <= 1'b0;
         full_duplex_out    <= 1'b1;
         collision_out      <= 1'b0;
      end else begin
         state_reg          <= state_next;
         count_reg          <= count_next;
         datapath_reset_out <= (state_next == reset_busy) || regs.control[power_down_pos];
         loopback_out       <= regs.control[loopback_pos] && fiber_or_bridge;
         speed_out          <= {regs.control[speed_high_pos], regs.control[speed_low_pos]};
         autoneg_on_out     <= regs.control[autoneg_en_pos] && an_mode;
         // isolate ignored for sgmii to rgmii
         isolate_out        <= regs.control[isolate_pos] && fiber_or_bridge && !sgmii_to_rgmii;
         full_duplex_out    <= mii_100fx ? regs.control[duplex_pos] : 1'b1;
         collision_out      <= regs.control[col_test_pos] && tx_enable_in;
      end
   end
endmodule

/* fiber_sgmii_ctrl_status_regs.sv */
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
// Operation
// - Writing one to soft reset resets fiber logic; bit clears itself afterwards.
// - Loopback bit loops MAC data in fiber and both bridge modes.
// - Speed code {high,low}: 0=10M, 1=100M, 2=1000M, 3 reserved.
// - Speed and autoneg enable reset values come from straps.
// - Autoneg enable bit turns negotiation on in 1000BASE-X and bridges.
// - Power down powers SGMII path off and holds digital in reset.
// - Isolate cuts MAC interface, except in SGMII-to-RGMII mode.
// - Restart bit restarts negotiation, then clears itself.
// - Forced duplex bit selects full or half, only in 100FX.
// - Collision test raises collision whenever transmit enable is high.
// - SGMII forced speed applies only while negotiation is disabled.
// - Status returns fixed capability bits.
// - Status always reports preamble suppression accepted.
// - Negotiation done bit reads one once negotiation finished.
// - Far end fault bit reads one when remote fault detected.
// - In fiber modes link bit shows fiber link.
// - RGMII-to-SGMII link needs partner link too when autoneg enabled.
// - SGMII-to-RGMII link bit shows partner link.
// - Registers from fiber base are shared by all fiber and bridge modes.
// - Bridge direction bit: zero SGMII-to-RGMII, one RGMII-to-SGMII.
module fiber_sgmii_ctrl_status_regs
   import fiber_regs_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        srst_in,
   // Avalon-MM slave, word addressed by byte address
   input  wire logic [13:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic [1:0]       avs_response,
   // Straps, pins
   input  wire logic [1:0]  strap_speed_in,
   input  wire logic        strap_autoneg_in,
   input  wire logic        fiber_link_in,
   input  wire logic        sgmii_link_in,
   input  wire logic        partner_link_in,
   input  wire logic        negotiation_done_in,
   input  wire logic        far_end_fault_in,
   input  wire logic [1:0]  negotiated_speed_in,
   input  wire logic        tx_enable_in,
   // Datapath controls
   output logic             datapath_reset_out,
   output logic             serdes_power_down_out,
   output logic             mac_side_loopback_out,
   output logic [1:0]       speed_out,
   output logic             autoneg_on_out,
   output logic             autoneg_restart_out,
   output logic             mac_interface_isolate_out,
   output logic             forced_duplex_out,
   output logic             collision_out
);
   import fiber_regs_pkg::*;

   fiber_reg_if regs ();

   logic [15:0] control_reg, control_next;
   logic [15:0] opmode_reg;
   logic        strap_loaded_reg;
   logic [1:0]  busy_seen_reg;
   logic        restart_reg;
   logic [31:0] readdata_reg;
   logic        waitrequest_reg;
   logic [1:0]  response_reg;
   logic [1:0]  speed_sel_reg;
   logic        power_down_reg;
   // Two-flop synchronisers for all pin inputs
   logic [6:0]  pins_meta_reg, pins_sync_reg;
   logic [1:0]  nspeed_meta_reg, nspeed_sync_reg;
   logic [2:0]  strap_meta_reg, strap_sync_reg;

   // Address decode; all four words map to index in [13:2]
   wire logic [11:0] word_index    = avs_address[13:2];
   wire logic        hit_control   = word_index == fiber_control_idx;
   wire logic        hit_status    = word_index == fiber_status_idx;
   wire logic        hit_opmode    = word_index == operating_mode_idx;
   wire logic        hit_links     = word_index == link_inputs_idx;
   wire logic        hit_any       = hit_control || hit_status || hit_opmode || hit_links;
   // Single wait cycle then answer
   wire logic        request       = (avs_read || avs_write) && waitrequest_reg;
   // Writes commit in the answer cycle, the one edge the master treats as the transfer
   wire logic        answer        = (avs_read || avs_write) && !waitrequest_reg;
   wire logic        write_ok      = avs_write && answer && avs_byteenable[0] && avs_byteenable[1];
   wire logic        ctl_write     = write_ok && hit_control;
   wire logic        mode_write    = write_ok && hit_opmode;

   wire logic fiber_link_s   = pins_sync_reg[0];
   wire logic sgmii_link_s   = pins_sync_reg[1];
   wire logic partner_link_s = pins_sync_reg[2];
   wire logic neg_done_s     = pins_sync_reg[3];
   wire logic far_fault_s    = pins_sync_reg[4];
   wire logic tx_enable_s    = pins_sync_reg[5];

   wire logic [2:0] opmode  = opmode_reg[2:0];
   wire logic rgmii_to_sgmii_bridge = (opmode == opmode_rgmii_sgmii) && opmode_reg[bridge_dir_pos];
   wire logic sgmii_to_rgmii_bridge = (opmode == opmode_sgmii_copper) ||
                                      ((opmode == opmode_rgmii_sgmii) && !opmode_reg[bridge_dir_pos]);
   wire logic an_enabled            = control_reg[autoneg_en_pos];
   wire logic bridge_link           = an_enabled ? (sgmii_link_s && partner_link_s) : sgmii_link_s;

   wire logic link_up_flag  = rgmii_to_sgmii_bridge ? bridge_link :
                              sgmii_to_rgmii_bridge ? partner_link_s : fiber_link_s;

   wire logic [15:0] status_word = fiber_status_fixed
                                 | (16'(neg_done_s) << neg_done_pos)
                                 | (16'(far_fault_s) << far_fault_pos)
                                 | (16'(link_up_flag) << link_up_pos);

   wire logic [15:0] link_word   = {11'h000, tx_enable_s, far_fault_s, neg_done_s, partner_link_s,
                                    sgmii_link_s | fiber_link_s};
   // one shared control/status pair for every mode
   wire logic [15:0] read_mux    = hit_control ? control_reg :
                                   hit_status  ? status_word :
                                   hit_opmode  ? opmode_reg  :
                                   hit_links   ? link_word   : 16'h0000;

   // forced speed only when SGMII negotiation off
   wire logic [1:0] speed_forced = {control_reg[speed_high_pos], control_reg[speed_low_pos]};
   wire logic sgmii_mode         = rgmii_to_sgmii_bridge || sgmii_to_rgmii_bridge;
   wire logic [1:0] speed_eff    = (sgmii_mode && an_enabled) ? nspeed_sync_reg : speed_forced;

   // Control register next value
   always_comb begin
      control_next = control_reg;
      if (ctl_write) begin
         control_next = avs_writedata[15:0] & control_write_mask;
      end
      // self clear after soft reset completes
      if (busy_seen_reg == 2'b10 && !ctl_write) begin
         control_next[soft_reset_pos] = 1'b0;
      end
      if (control_reg[restart_pos] && !ctl_write) begin
         control_next[restart_pos] = 1'b0;
      end
      // strap values replace speed and autoneg once after reset release
      if (!strap_loaded_reg) begin
         control_next[speed_low_pos]  = strap_sync_reg[0];
         control_next[speed_high_pos] = strap_sync_reg[1];
         control_next[autoneg_en_pos] = strap_sync_reg[2];
      end
   end

   assign regs.control = control_reg;
   assign regs.opmode  = opmode_reg;

   fiber_mode_logic mode_logic (
      .clock_in           (clock_in),
      .srst_in            (srst_in),
      .regs               (regs),
      .start_reset_in     (ctl_write && avs_writedata[soft_reset_pos]),
      .tx_enable_in       (tx_enable_s),
      .datapath_reset_out (datapath_reset_out),
      .loopback_out       (mac_side_loopback_out),
      .speed_out          (),
      .autoneg_on_out     (autoneg_on_out),
      .isolate_out        (mac_interface_isolate_out),
      .full_duplex_out    (forced_duplex_out),
      .collision_out      (collision_out)
   );

   // Pin synchronisers
   always_ff @(posedge clock_in) begin
      pins_meta_reg   <= {1'b0, tx_enable_in, far_end_fault_in, negotiation_done_in, partner_link_in,
                          sgmii_link_in, fiber_link_in};
      pins_sync_reg   <= pins_meta_reg;
      nspeed_meta_reg <= negotiated_speed_in;
      nspeed_sync_reg <= nspeed_meta_reg;
      // Straps settle through the synchroniser while reset is still held
      strap_meta_reg  <= {strap_autoneg_in, strap_speed_in};
      strap_sync_reg  <= strap_meta_reg;
   end

   // Register bank and bus answer
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         control_reg      <= fiber_control_reset;
         opmode_reg       <= operating_mode_reset;
         strap_loaded_reg <= 1'b0;
         busy_seen_reg    <= 2'b00;
         waitrequest_reg  <= 1'b1;
         readdata_reg     <= 32'h0000_0000;
         response_reg     <= 2'b00;
      end else begin
         control_reg      <= control_next;
         strap_loaded_reg <= 1'b1;
         busy_seen_reg    <= {busy_seen_reg[0], regs.soft_reset_busy};
         if (mode_write) opmode_reg <= avs_writedata[15:0] & 16'h0067;
         waitrequest_reg  <= !request;
         if (request) begin
            readdata_reg  <= {16'h0000, read_mux};
            response_reg  <= hit_any ? 2'b00 : 2'b11;
         end else begin
            readdata_reg  <= 32'h0000_0000;
            response_reg  <= 2'b00;
         end
      end
   end

   // Datapath outputs straight from flops
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         speed_sel_reg  <= 2'h2;
         power_down_reg <= 1'b0;
         restart_reg    <= 1'b0;
      end else begin
         // reserved speed code keeps previous rate
         if (speed_eff != speed_reserved) speed_sel_reg <= speed_eff;
         power_down_reg <= control_reg[power_down_pos];
         restart_reg    <= control_reg[restart_pos] && (sgmii_mode || opmode == opmode_rgmii_1000x ||
                                                        opmode == opmode_mc_1000x);
      end
   end

   assign avs_readdata          = readdata_reg;
   assign avs_waitrequest       = waitrequest_reg;
   assign avs_response          = response_reg;
   assign speed_out             = speed_sel_reg;
   assign serdes_power_down_out = power_down_reg;
   assign autoneg_restart_out   = restart_reg;
endmodule

/* fiber_regs_sva.sv */
`timescale 1ns/1ps
// Bus answer and control-pin relations of the fiber register bank
module fiber_regs_sva
   import fiber_regs_pkg::*;
(
   input wire logic        clock_in,
   input wire logic        srst_in,
   input wire logic [13:0] avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [1:0]  avs_response,
   input wire logic        tx_enable_in,
   input wire logic        datapath_reset_out,
   input wire logic        serdes_power_down_out,
   input wire logic [1:0]  speed_out,
   input wire logic        autoneg_restart_out,
   input wire logic        collision_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (srst_in);
   // Taken request and the word it targets
   wire logic        take = (avs_read || avs_write) && avs_waitrequest;
   wire logic [11:0] idx  = avs_address[13:2];
   wire logic        hit  = idx == fiber_control_idx || idx == fiber_status_idx || idx == operating_mode_idx
                            || idx == link_inputs_idx;
   // Pulses are judged against the write that caused them, since the pins are registered
   property p_answer; take |=> !avs_waitrequest ##1 avs_waitrequest; endproperty
   a_answer: assert property (p_answer) else $error("Answer not one cycle long");
   property p_idle; avs_waitrequest |-> avs_readdata == 32'h0 && avs_response == 2'h0; endproperty
   a_idle: assert property (p_idle) else $error("Read data outside answer");
   property p_decode; take |=> avs_response == ($past(hit) ? 2'h0 : 2'h3); endproperty
   a_decode: assert property (p_decode) else $error("Wrong response code");
   property p_status;
      take && avs_read && idx == fiber_status_idx |=> (avs_readdata[15:0] & 16'hffcb) == fiber_status_fixed;
   endproperty
   a_status: assert property (p_status) else $error("Fixed status bits wrong");
   property p_rsvd; take && avs_read && idx == fiber_control_idx |=> avs_readdata[5:0] == 6'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("Reserved control bits not zero");
   property p_power; serdes_power_down_out && $past(serdes_power_down_out) |-> datapath_reset_out; endproperty
   a_power: assert property (p_power) else $error("Logic not held in reset");
   property p_col;
      collision_out |-> $past(tx_enable_in, 2) || $past(tx_enable_in, 3) || $past(tx_enable_in, 4);
   endproperty
   a_col: assert property (p_col) else $error("Collision without transmit");
   property p_restart;
      autoneg_restart_out |-> ($past(avs_write) || $past(avs_write, 2)) ##1 !autoneg_restart_out;
   endproperty
   a_restart: assert property (p_restart) else $error("Restart pulse malformed");
   property p_speed; speed_out != speed_reserved; endproperty
   a_speed: assert property (p_speed) else $error("Reserved speed applied");
   c_write: cover property (take && avs_write);
   c_col: cover property (collision_out);
   c_restart: cover property (autoneg_restart_out);
endmodule

bind fiber_sgmii_ctrl_status_regs fiber_regs_sva u_sva (.clock_in, .srst_in, .avs_address, .avs_read, .avs_write,
   .avs_readdata, .avs_waitrequest, .avs_response, .tx_enable_in, .datapath_reset_out, .serdes_power_down_out,
   .speed_out, .autoneg_restart_out, .collision_out);

/* mgmt_host_model.sv */
`timescale 1ns/1ps
// Management host: bus master that holds each request until it is answered
module mgmt_host_model (
   input  wire logic        clock_in,
   input  wire logic        avs_waitrequest,
   input  wire logic [31:0] avs_readdata,
   input  wire logic [1:0]  avs_response,
   output logic [13:0]      avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata,
   output logic [3:0]       avs_byteenable
);
   // Quiet bus until the first request
   initial begin
      avs_address = 14'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
   end
   // One access; the leading edge keeps back-to-back calls from driving twice in one step
   task automatic access(input logic wr, input logic [11:0] idx, input logic [15:0] wd, input logic [3:0] be,
      output logic [31:0] rd, output logic [1:0] rs);
      @(posedge clock_in);
      avs_address <= {idx, 2'h0};
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {16'h0, wd};
      avs_byteenable <= be;
      @(posedge clock_in);
      while (avs_waitrequest !== 1'b0) @(posedge clock_in);
      rd = avs_readdata;
      rs = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ps
// Self-checking bench for the fiber control and status registers
module testbench;
   import fiber_regs_pkg::*;
   // Row: write flag, index, data, enables, link pins, read value, response, control pins
   typedef struct packed {
      logic [3:0]  wr;
      logic [11:0] idx;
      logic [15:0] wd;
      logic [3:0]  be;
      logic [7:0]  lnk;
      logic [15:0] exp;
      logic [3:0]  rsp;
      logic [7:0]  pins;
   } row_t;
   logic        clock_in, srst_in, avs_read, avs_write, avs_waitrequest, strap_autoneg_in, tx_enable_in;
   logic        datapath_reset_out, serdes_power_down_out, autoneg_restart_out, collision_out;
   logic [13:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0]  avs_byteenable;
   logic [1:0]  avs_response, strap_speed_in, negotiated_speed_in, rs;
   logic [4:0]  lnk_in;
   wire  [5:0]  pins;
   logic [7:0]  n_pulse = 8'h0;
   int          n_errors = 0;
   int          n_tests = 0;
   int          cycles = 0;
   row_t        rows [26] = '{
      72'h0_c00_0000_f_00_2100_0_05, 72'h0_c01_0000_f_00_6149_0_05,
      72'h1_c00_403f_f_00_0000_0_04, 72'h0_c00_0000_f_00_4000_0_04,
      72'h1_c01_ffff_f_00_0000_0_04, 72'h0_c01_0000_f_00_6149_0_04,
      72'h0_c02_0000_f_00_0000_3_04, 72'h1_7ff_1234_f_00_0000_3_04,
      72'h1_c00_0000_c_00_0000_0_04, 72'h0_c00_0000_f_00_4000_0_04,
      72'h0_c08_0000_f_00_0040_0_04, 72'h1_c08_0041_f_00_0000_0_24,
      72'h1_c00_1480_f_00_0000_0_1c, 72'h1_c08_0045_f_00_0000_0_08,
      72'h1_c08_0006_f_00_0000_0_16, 72'h1_c00_2000_f_00_0000_0_05,
      72'h0_c01_0000_f_04_614d_0_05, 72'h0_c01_0000_f_18_6149_0_05,
      72'h1_c08_0043_f_08_0000_0_05, 72'h0_c01_0000_f_08_614d_0_05,
      72'h1_c00_3000_f_08_0000_0_16, 72'h0_c01_0000_f_08_6149_0_16,
      72'h0_c01_0000_f_0c_614d_0_16, 72'h1_c08_0041_f_0c_0000_0_15,
      72'h0_c01_0000_f_13_617d_0_15, 72'h0_c01_0000_f_00_6149_0_15};
   mgmt_host_model host (.clock_in, .avs_waitrequest, .avs_readdata, .avs_response, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable);
   fiber_sgmii_ctrl_status_regs DUT (.clock_in, .srst_in, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .strap_speed_in, .strap_autoneg_in,
      .fiber_link_in(lnk_in[4]), .sgmii_link_in(lnk_in[3]), .partner_link_in(lnk_in[2]),
      .negotiation_done_in(lnk_in[1]), .far_end_fault_in(lnk_in[0]), .negotiated_speed_in, .tx_enable_in,
      .datapath_reset_out, .serdes_power_down_out, .mac_side_loopback_out(pins[5]), .speed_out(pins[1:0]),
      .autoneg_on_out(pins[4]), .autoneg_restart_out, .mac_interface_isolate_out(pins[3]),
      .forced_duplex_out(pins[2]), .collision_out);
   // Clock at 250 MHz
   initial begin
      clock_in = 1'b0;
      forever #2 clock_in = ~clock_in;
   end
   // Restart pulses counted apart, since one lasts a single cycle
   always @(posedge clock_in) n_pulse <= n_pulse + {7'h0, autoneg_restart_out === 1'b1};
   // A hang counts as a mismatch
   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_errors = n_errors + 1;
         give_verdict();
      end
   end
   task automatic check_read(input logic [33:0] got, input logic [33:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("Error t=%0t read %h exp %h", $time, got, exp);
      end
   endtask
   task automatic check_pin(input logic [7:0] got, input logic [7:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("Error t=%0t pins %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] i, input logic [15:0] d);
      host.access(1'b1, i, d, 4'hf, rd, rs);
      repeat (4) @(posedge clock_in);
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      srst_in = 1'b1;
      strap_speed_in = 2'h1;
      strap_autoneg_in = 1'b0;
      lnk_in = 5'h0;
      negotiated_speed_in = 2'h2;
      tx_enable_in = 1'b0;
      repeat (20) @(posedge clock_in);
      srst_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      for (int i = 0; i < 26; i++) begin
         lnk_in <= rows[i].lnk[4:0];
         repeat (4) @(posedge clock_in);
         host.access(rows[i].wr[0], rows[i].idx, rows[i].wd, rows[i].be, rd, rs);
         check_read({rs, rows[i].wr[0] ? 32'h0 : rd}, {rows[i].rsp[1:0], 16'h0, rows[i].exp});
         repeat (3) @(posedge clock_in);
         check_pin({2'h0, pins}, rows[i].pins);
      end
      wr(fiber_control_idx, 16'h3080);
      tx_enable_in <= 1'b1;
      repeat (6) @(posedge clock_in);
      check_pin({7'h0, collision_out}, 8'h1);
      tx_enable_in <= 1'b0;
      repeat (6) @(posedge clock_in);
      check_pin({7'h0, collision_out}, 8'h0);
      wr(fiber_control_idx, 16'h3280);
      check_pin(n_pulse, 8'h1);
      host.access(1'b0, fiber_control_idx, 16'h0, 4'hf, rd, rs);
      check_read({rs, rd}, 34'h3080);
      wr(fiber_control_idx, 16'h3880);
      check_pin({6'h0, serdes_power_down_out, datapath_reset_out}, 8'h3);
      wr(fiber_control_idx, 16'h3080);
      check_pin({6'h0, serdes_power_down_out, datapath_reset_out}, 8'h0);
      wr(fiber_control_idx, 16'hb080);
      check_pin({7'h0, datapath_reset_out}, 8'h1);
      repeat (30) @(posedge clock_in);
      check_pin({7'h0, datapath_reset_out}, 8'h0);
      host.access(1'b0, fiber_control_idx, 16'h0, 4'hf, rd, rs);
      check_read({rs, rd & 32'h8000}, 34'h0);
      strap_speed_in <= 2'h2;
      strap_autoneg_in <= 1'b1;
      srst_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      srst_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      host.access(1'b0, fiber_control_idx, 16'h0, 4'hf, rd, rs);
      check_read({rs, rd}, 34'h1140);
      repeat (3) @(posedge clock_in);
      check_pin({2'h0, pins}, 8'h06);
      give_verdict();
   end
endmodule
